// ==== core/mivs_pkg.sv ====
package mivs_pkg;
   localparam logic [31:0] BASE_RESET = 32'h0003_0000;
   localparam logic [31:0] OFF_EPT_CTL = 32'h0000_fee0;
   localparam logic [31:0] OFF_EPT_PTR = 32'h0000_fed8;
   localparam int ROOT_MSB = 51;
   localparam int ROOT_LSB = 12;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int PTR_W = 64;
   localparam logic [1:0] CPL_RESET = 2'h0;
   localparam logic [DATA_W-1:0] CTL_ONE = 64'h0000_0000_0000_0001;
   localparam logic [DATA_W-1:0] CTL_ZERO = 64'h0000_0000_0000_0000;
   typedef enum logic [3:0] {
      MIVS_IDLE, MIVS_E_CLR, MIVS_E_CTL, MIVS_E_PTR, MIVS_E_SAVE, MIVS_E_LOAD,
      MIVS_SMM, MIVS_R_CHK, MIVS_R_REST, MIVS_R_EXIT, MIVS_SHUT
   } mivs_state_t;
endpackage : mivs_pkg

// ==== core/mivs_seq.sv ====
`timescale 1ns/1ps
module mivs_seq #(
   parameter bit SMX_SUPPORTED = 1'b1,
   parameter bit EPT_SUPPORTED = 1'b1,
   parameter bit SAVE_SHADOW = 1'b1
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic mgmt_interrupt_req,
   input wire logic init_req,
   input wire logic resume_instruction,
   input wire logic vmxe_wr,
   input wire logic vmxe_wr_val,
   input wire logic vmx_enter_root,
   input wire logic vmx_enter_guest,
   input wire logic vmx_leave,
   input wire logic vmx_instr,
   input wire logic [mivs_pkg::PTR_W-1:0] virt_control_structure_ptr_in,
   input wire logic [1:0] stack_descriptor_privilege,
   input wire logic virtual_8086_flag,
   input wire logic shadow_blk_in,
   input wire logic vnmi_blk_in,
   input wire logic vnmi_ctl_in,
   input wire logic mtf_pending_in,
   input wire logic ept_ctl_in,
   input wire logic [mivs_pkg::PTR_W-1:0] extended_table_pointer_in,
   input wire logic unrestricted_guest,
   input wire logic saved_virtualization_enable_bit,
   input wire logic saved_nmi_blk,
   input wire logic [mivs_pkg::ADDR_W-1:0] saved_base,
   input wire logic safer_mode_active,
   input wire logic intwin_ctl,
   input wire logic intwin_cond,
   input wire logic nmiwin_ctl,
   input wire logic nmiwin_cond,
   input wire logic halted,
   output logic smm_active_r,
   output logic vmxe_r,
   output logic vmx_root_r,
   output logic vmx_guest_r,
   output logic [mivs_pkg::PTR_W-1:0] virt_control_structure_ptr_r,
   output logic space_locked_r,
   output logic mem_wr_r,
   output logic mem_wide_r,
   output logic [mivs_pkg::ADDR_W-1:0] mem_addr_r,
   output logic [mivs_pkg::DATA_W-1:0] mem_data_r,
   output logic save_state_r,
   output logic load_std_r,
   output logic restore_state_r,
   output logic flush_vpid0_r,
   output logic flush_all_r,
   output logic force_fixed_r,
   output logic [1:0] cpl_r,
   output logic v86_r,
   output logic shadow_blk_r,
   output logic vnmi_blk_r,
   output logic [1:0] code_requested_privilege_r,
   output logic [1:0] stack_requested_privilege_r,
   output logic shutdown_r,
   output logic smi_blocked_r,
   output logic nmi_blocked_r,
   output logic init_blocked_r,
   output logic address_bit20_mask_blocked_r,
   output logic gp_fault_r,
   output logic vm_exit_r,
   output logic mtf_exit_r,
   output logic mtf_post_r,
   output logic debug_trap_hold_r,
   output logic wake_r,
   output logic [mivs_pkg::ADDR_W-1:0] mgmt_base_address_r
);
   mivs_pkg::mivs_state_t st_r, st_nxt;
   logic sv_vmxe_r, sv_vmxe_nxt, sv_root_r, sv_root_nxt, sv_guest_r, sv_guest_nxt;
   logic sv_lock_r, sv_lock_nxt, sv_mtf_r, sv_mtf_nxt, sv_vnctl_r, sv_vnctl_nxt;
   logic sv_ept_r, sv_ept_nxt;
   logic [mivs_pkg::PTR_W-1:0] sv_virt_control_structure_r, sv_virt_control_structure_nxt, sv_extended_table_pointer_r, sv_extended_table_pointer_nxt;
   logic smm_nxt, vmxe_nxt, root_nxt, guest_nxt, lock_nxt, wr_nxt, wide_nxt;
   logic [mivs_pkg::PTR_W-1:0] virt_control_structure_nxt;
   logic [mivs_pkg::ADDR_W-1:0] addr_nxt, base_nxt;
   logic [mivs_pkg::DATA_W-1:0] data_nxt;
   logic save_nxt, load_nxt, rest_nxt, fl0_nxt, fla_nxt, fix_nxt, v86_nxt, shb_nxt;
   logic vnb_nxt, shut_nxt, smib_nxt, nmib_nxt, initb_nxt, a20_nxt, gp_nxt;
   logic vmx_nxt, mtfx_nxt, mtfp_nxt, dbg_nxt, wake_nxt;
   logic [1:0] cpl_nxt, csr_nxt, ssr_nxt;
   logic take_smi, virt_now, mtf_fire;

   // with shadow state not saved the interrupt must wait out the shadow
   assign take_smi = mgmt_interrupt_req && st_r == mivs_pkg::MIVS_IDLE &&
                     (SAVE_SHADOW || !shadow_blk_in);
   assign virt_now = vmx_root_r || vmx_guest_r;
   assign mtf_fire = mtf_post_r && !mgmt_interrupt_req && !init_req;

   always_comb begin
      st_nxt = st_r;
      sv_vmxe_nxt = sv_vmxe_r;
      sv_root_nxt = sv_root_r;
      sv_guest_nxt = sv_guest_r;
      sv_lock_nxt = sv_lock_r;
      sv_mtf_nxt = sv_mtf_r;
      sv_vnctl_nxt = sv_vnctl_r;
      sv_ept_nxt = sv_ept_r;
      sv_virt_control_structure_nxt = sv_virt_control_structure_r;
      sv_extended_table_pointer_nxt = sv_extended_table_pointer_r;
      smm_nxt = smm_active_r;
      vmxe_nxt = vmxe_r;
      root_nxt = vmx_root_r;
      guest_nxt = vmx_guest_r;
      virt_control_structure_nxt = virt_control_structure_ptr_r;
      lock_nxt = space_locked_r;
      wr_nxt = 1'b0;
      wide_nxt = mem_wide_r;
      addr_nxt = mem_addr_r;
      data_nxt = mem_data_r;
      save_nxt = 1'b0;
      load_nxt = 1'b0;
      rest_nxt = 1'b0;
      fl0_nxt = 1'b0;
      fla_nxt = 1'b0;
      fix_nxt = 1'b0;
      cpl_nxt = cpl_r;
      v86_nxt = v86_r;
      shb_nxt = shadow_blk_r;
      vnb_nxt = vnmi_blk_r;
      csr_nxt = code_requested_privilege_r;
      ssr_nxt = stack_requested_privilege_r;
      shut_nxt = shutdown_r;
      smib_nxt = smi_blocked_r;
      nmib_nxt = nmi_blocked_r;
      initb_nxt = init_blocked_r;
      a20_nxt = address_bit20_mask_blocked_r;
      gp_nxt = 1'b0;
      vmx_nxt = 1'b0;
      mtfx_nxt = 1'b0;
      mtfp_nxt = mtf_post_r;
      dbg_nxt = 1'b0;
      wake_nxt = 1'b0;
      base_nxt = mgmt_base_address_r;
      if (mtf_fire) begin
         mtfx_nxt = 1'b1;
         mtfp_nxt = 1'b0;
         wake_nxt = halted;
      end
      dbg_nxt = mtfp_nxt;
      unique case (st_r)
         mivs_pkg::MIVS_IDLE: begin
            if (vmxe_wr) vmxe_nxt = vmxe_wr_val;
            if (vmx_enter_root && vmxe_r) root_nxt = 1'b1;
            if (vmx_enter_guest && vmx_root_r) begin
               root_nxt = 1'b0;
               guest_nxt = 1'b1;
            end
            if (vmx_leave) begin
               root_nxt = 1'b0;
               guest_nxt = 1'b0;
            end
            if (take_smi) begin
               st_nxt = mivs_pkg::MIVS_E_CLR;
               smm_nxt = 1'b1;
               smib_nxt = 1'b1;
               nmib_nxt = 1'b1;
               initb_nxt = 1'b1;
               mtfx_nxt = 1'b0;
               mtfp_nxt = 1'b0;
               wake_nxt = 1'b0;
               sv_vmxe_nxt = vmxe_r;
               sv_root_nxt = vmx_root_r;
               sv_guest_nxt = vmx_guest_r;
               sv_ept_nxt = EPT_SUPPORTED && vmx_guest_r && ept_ctl_in;
               sv_extended_table_pointer_nxt = extended_table_pointer_in;
               if (virt_now) begin
                  sv_virt_control_structure_nxt = virt_control_structure_ptr_in;
                  root_nxt = 1'b0;
                  guest_nxt = 1'b0;
                  cpl_nxt = stack_descriptor_privilege;
                  v86_nxt = virtual_8086_flag;
                  shb_nxt = SAVE_SHADOW && shadow_blk_in;
                  sv_vnctl_nxt = vmx_guest_r && vnmi_ctl_in;
                  vnb_nxt = vmx_guest_r && vnmi_ctl_in && vnmi_blk_in;
                  sv_mtf_nxt = vmx_guest_r && (mtf_pending_in || mtf_post_r);
               end
               if (SMX_SUPPORTED) begin
                  sv_lock_nxt = space_locked_r;
                  lock_nxt = 1'b1;
               end
            end
         end
         mivs_pkg::MIVS_E_CLR: begin
            vmxe_nxt = 1'b0;
            st_nxt = EPT_SUPPORTED ? mivs_pkg::MIVS_E_CTL : mivs_pkg::MIVS_E_SAVE;
         end
         mivs_pkg::MIVS_E_CTL: begin
            wr_nxt = 1'b1;
            wide_nxt = 1'b0;
            addr_nxt = mgmt_base_address_r + mivs_pkg::OFF_EPT_CTL;
            data_nxt = sv_ept_r ? mivs_pkg::CTL_ONE : mivs_pkg::CTL_ZERO;
            st_nxt = sv_ept_r ? mivs_pkg::MIVS_E_PTR : mivs_pkg::MIVS_E_SAVE;
         end
         mivs_pkg::MIVS_E_PTR: begin
            wr_nxt = 1'b1;
            wide_nxt = 1'b1;
            addr_nxt = mgmt_base_address_r + mivs_pkg::OFF_EPT_PTR;
            data_nxt = sv_extended_table_pointer_r;
            st_nxt = mivs_pkg::MIVS_E_SAVE;
         end
         mivs_pkg::MIVS_E_SAVE: begin
            save_nxt = 1'b1;
            st_nxt = mivs_pkg::MIVS_E_LOAD;
         end
         mivs_pkg::MIVS_E_LOAD: begin
            load_nxt = 1'b1;
            fl0_nxt = 1'b1;
            st_nxt = mivs_pkg::MIVS_SMM;
         end
         mivs_pkg::MIVS_SMM: begin
            // enable bit is reserved here and guest entry is refused
            if ((vmxe_wr && vmxe_wr_val) || vmx_instr || vmx_enter_root ||
                vmx_enter_guest) gp_nxt = 1'b1;
            if (resume_instruction) st_nxt = mivs_pkg::MIVS_R_CHK;
         end
         mivs_pkg::MIVS_R_CHK: begin
            if (saved_virtualization_enable_bit) begin
               st_nxt = mivs_pkg::MIVS_SHUT;
               shut_nxt = 1'b1;
               sv_mtf_nxt = 1'b0;
            end else begin
               st_nxt = mivs_pkg::MIVS_R_REST;
               rest_nxt = 1'b1;
               fla_nxt = 1'b1;
               base_nxt = saved_base;
            end
         end
         mivs_pkg::MIVS_R_REST: begin
            if (SMX_SUPPORTED && !sv_lock_r) lock_nxt = 1'b0;
            vmxe_nxt = sv_vmxe_r;
            if (sv_root_r || sv_guest_r) begin
               root_nxt = sv_root_r;
               guest_nxt = sv_guest_r;
               fix_nxt = 1'b1;
               virt_control_structure_nxt = sv_virt_control_structure_r;
               if (!v86_r && (sv_root_r || !unrestricted_guest)) begin
                  csr_nxt = cpl_r;
                  ssr_nxt = cpl_r;
               end
            end
            st_nxt = mivs_pkg::MIVS_R_EXIT;
         end
         mivs_pkg::MIVS_R_EXIT: begin
            smm_nxt = 1'b0;
            smib_nxt = 1'b0;
            nmib_nxt = (vmx_guest_r && sv_vnctl_r) ? 1'b0 : saved_nmi_blk;
            initb_nxt = vmx_root_r;
            a20_nxt = virt_now || safer_mode_active;
            vmx_nxt = vmx_guest_r && ((intwin_ctl && intwin_cond) ||
                                      (nmiwin_ctl && nmiwin_cond));
            mtfp_nxt = sv_mtf_r;
            dbg_nxt = sv_mtf_r;
            st_nxt = mivs_pkg::MIVS_IDLE;
         end
         mivs_pkg::MIVS_SHUT: begin
            st_nxt = mivs_pkg::MIVS_SHUT;
         end
         default: st_nxt = mivs_pkg::MIVS_SHUT;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r <= mivs_pkg::MIVS_IDLE;
         {sv_vmxe_r, sv_root_r, sv_guest_r, sv_lock_r} <= 4'h0;
         {sv_mtf_r, sv_vnctl_r, sv_ept_r} <= 3'h0;
         sv_virt_control_structure_r <= '0;
         sv_extended_table_pointer_r <= '0;
         {smm_active_r, vmxe_r, vmx_root_r, vmx_guest_r, space_locked_r} <= 5'h00;
         virt_control_structure_ptr_r <= '0;
         {mem_wr_r, mem_wide_r} <= 2'h0;
         mem_addr_r <= '0;
         mem_data_r <= '0;
         {save_state_r, load_std_r, restore_state_r, flush_vpid0_r} <= 4'h0;
         {flush_all_r, force_fixed_r, v86_r, shadow_blk_r, vnmi_blk_r} <= 5'h00;
         cpl_r <= mivs_pkg::CPL_RESET;
         code_requested_privilege_r <= mivs_pkg::CPL_RESET;
         stack_requested_privilege_r <= mivs_pkg::CPL_RESET;
         {shutdown_r, smi_blocked_r, nmi_blocked_r, init_blocked_r} <= 4'h0;
         {address_bit20_mask_blocked_r, gp_fault_r, vm_exit_r, mtf_exit_r} <= 4'h0;
         {mtf_post_r, debug_trap_hold_r, wake_r} <= 3'h0;
         mgmt_base_address_r <= mivs_pkg::BASE_RESET;
      end else begin
         st_r <= st_nxt;
         {sv_vmxe_r, sv_root_r, sv_guest_r, sv_lock_r} <=
            {sv_vmxe_nxt, sv_root_nxt, sv_guest_nxt, sv_lock_nxt};
         {sv_mtf_r, sv_vnctl_r, sv_ept_r} <= {sv_mtf_nxt, sv_vnctl_nxt, sv_ept_nxt};
         sv_virt_control_structure_r <= sv_virt_control_structure_nxt;
         sv_extended_table_pointer_r <= sv_extended_table_pointer_nxt;
         {smm_active_r, vmxe_r, vmx_root_r, vmx_guest_r, space_locked_r} <=
            {smm_nxt, vmxe_nxt, root_nxt, guest_nxt, lock_nxt};
         virt_control_structure_ptr_r <= virt_control_structure_nxt;
         {mem_wr_r, mem_wide_r} <= {wr_nxt, wide_nxt};
         mem_addr_r <= addr_nxt;
         mem_data_r <= data_nxt;
         {save_state_r, load_std_r, restore_state_r, flush_vpid0_r} <=
            {save_nxt, load_nxt, rest_nxt, fl0_nxt};
         {flush_all_r, force_fixed_r, v86_r, shadow_blk_r, vnmi_blk_r} <=
            {fla_nxt, fix_nxt, v86_nxt, shb_nxt, vnb_nxt};
         cpl_r <= cpl_nxt;
         code_requested_privilege_r <= csr_nxt;
         stack_requested_privilege_r <= ssr_nxt;
         {shutdown_r, smi_blocked_r, nmi_blocked_r, init_blocked_r} <=
            {shut_nxt, smib_nxt, nmib_nxt, initb_nxt};
         {address_bit20_mask_blocked_r, gp_fault_r, vm_exit_r, mtf_exit_r} <=
            {a20_nxt, gp_nxt, vmx_nxt, mtfx_nxt};
         {mtf_post_r, debug_trap_hold_r, wake_r} <= {mtfp_nxt, dbg_nxt, wake_nxt};
         mgmt_base_address_r <= base_nxt;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_entry_clears_vmxe;
      take_smi |=> ##1 !vmxe_r && !vmx_root_r && !vmx_guest_r;
   endproperty
   a_entry_clears_vmxe: assert property (p_entry_clears_vmxe)
      else $error("enable bit or mode not cleared on entry");
   property p_entry_locks;
      take_smi |=> space_locked_r || !SMX_SUPPORTED;
   endproperty
   a_entry_locks: assert property (p_entry_locks)
      else $error("private space not locked on entry");
   property p_ctl_addr;
      mem_wr_r && !mem_wide_r |-> mem_addr_r == mgmt_base_address_r + mivs_pkg::OFF_EPT_CTL;
   endproperty
   a_ctl_addr: assert property (p_ctl_addr)
      else $error("control word written to wrong address");
   property p_ptr_follows_one;
      mem_wr_r && mem_wide_r |-> $past(mem_wr_r) && $past(mem_data_r) == mivs_pkg::CTL_ONE;
   endproperty
   a_ptr_follows_one: assert property (p_ptr_follows_one)
      else $error("pointer written without control bit one");
   property p_flush0;
      take_smi |-> ##[4:6] flush_vpid0_r;
   endproperty
   a_flush0: assert property (p_flush0)
      else $error("identifier-zero flush missing after entry");
   property p_no_exit_in_smm;
      smm_active_r |-> !vm_exit_r;
   endproperty
   a_no_exit_in_smm: assert property (p_no_exit_in_smm)
      else $error("guest exit while in management mode");
   property p_shutdown;
      st_r == mivs_pkg::MIVS_R_CHK && saved_virtualization_enable_bit |=> shutdown_r [*3];
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("resume with set enable bit did not shut down");
   property p_gp;
      st_r == mivs_pkg::MIVS_SMM && vmxe_wr && vmxe_wr_val |=> gp_fault_r && !vmxe_r;
   endproperty
   a_gp: assert property (p_gp)
      else $error("setting enable bit in management mode not faulted");
   property p_init_blk;
      $fell(smm_active_r) |-> init_blocked_r == vmx_root_r;
   endproperty
   a_init_blk: assert property (p_init_blk)
      else $error("INIT blocking wrong after resume");
   property p_no_reentry;
      smm_active_r && !$fell(smm_active_r) |-> smi_blocked_r;
   endproperty
   a_no_reentry: assert property (p_no_reentry)
      else $error("interrupt unblocked inside management mode");
   property p_mtf_prio;
      mtf_exit_r |-> !$past(mgmt_interrupt_req) && !$past(init_req);
   endproperty
   a_mtf_prio: assert property (p_mtf_prio)
      else $error("trap exit taken over higher priority event");

   c_entry_guest: cover property (take_smi && vmx_guest_r ##[1:8] mem_wr_r && mem_wide_r);
   c_resume_ok: cover property (resume_instruction ##[1:4] $fell(smm_active_r));
   c_shutdown: cover property ($rose(shutdown_r));
   c_mtf_wake: cover property (mtf_exit_r && wake_r);
endmodule : mivs_seq

// ==== dv/mivs_handler_model.sv ====
`timescale 1ns/1ps
// interrupt source plus handler: raises the request on fire, issues the resume
// a fixed while after the standard state load; the saved image comes from inputs
module mivs_handler_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic fire,
   input wire logic keep_req,
   input wire logic bad_image,
   input wire logic [31:0] new_base,
   input wire logic smm_active_r,
   input wire logic load_std_r,
   output logic mgmt_interrupt_req,
   output logic resume_instruction,
   output logic saved_virtualization_enable_bit,
   output logic saved_nmi_blk,
   output logic [31:0] saved_base
);
   logic [3:0] cnt;
   // a bad image leaves the enable bit set so the resume must fail
   assign saved_virtualization_enable_bit = bad_image;
   // the image shows NMIs blocked only while the request is held, so both values occur
   assign saved_nmi_blk = keep_req;
   assign saved_base = new_base;
   always @(negedge clk_sys) begin
      resume_instruction <= 1'b0;
      if (sys_rst) begin
         mgmt_interrupt_req <= 1'b0;
         cnt <= 4'h0;
      end else begin
         // keep_req holds the line up through the handler to probe re-entry
         if (fire)
            mgmt_interrupt_req <= 1'b1;
         else if (smm_active_r && !keep_req)
            mgmt_interrupt_req <= 1'b0;
         if (load_std_r)
            cnt <= 4'hc;
         else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            resume_instruction <= (cnt == 4'h1);
         end
      end
   end
endmodule : mivs_handler_model

// ==== dv/test_mgmt_interrupt_virt_state_sequencer.sv ====
`timescale 1ns/1ps
module test_mgmt_interrupt_virt_state_sequencer;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic fire, keep_req, bad_image, init_req, vmxe_wr, vmxe_wr_val, vmx_enter_root;
   logic vmx_enter_guest, vmx_instr, virtual_8086_flag, vnmi_blk_in, vnmi_ctl_in;
   logic mtf_pending_in, ept_ctl_in, unrestricted_guest, intwin_ctl, intwin_cond, halted;
   logic mgmt_interrupt_req, resume_instruction, saved_virtualization_enable_bit, saved_nmi_blk;
   logic [31:0] new_base, saved_base, mem_addr_r, mgmt_base_address_r, ctl_a, wide_a;
   logic [63:0] virt_control_structure_ptr_in, extended_table_pointer_in, virt_control_structure_ptr_r, mem_data_r, ctl_d, wide_d;
   logic [1:0] stack_descriptor_privilege, cpl_r;
   logic [1:0] code_requested_privilege_r, stack_requested_privilege_r;
   logic smm_active_r, vmxe_r, vmx_root_r, vmx_guest_r, space_locked_r, mem_wr_r, mem_wide_r;
   logic save_state_r, load_std_r, restore_state_r, flush_vpid0_r, flush_all_r, force_fixed_r;
   logic v86_r, shadow_blk_r, vnmi_blk_r, shutdown_r, smi_blocked_r, nmi_blocked_r;
   logic init_blocked_r, address_bit20_mask_blocked_r, gp_fault_r, vm_exit_r, mtf_exit_r, mtf_post_r;
   logic debug_trap_hold_r, wake_r, wk, smm_q;
   logic shadow_blk_in, safer_mode_active, vmx_leave, nmiwin_ctl, nmiwin_cond;
   int n_fail = 0, n_tests = 0, cyc = 0, t_in, t_fl;
   int n_ctl, n_wide, n_fa, n_gp, n_vx, n_mtf, n_sv, n_ff;

   mivs_seq i_mivs_seq (.clk_sys, .sys_rst, .mgmt_interrupt_req, .init_req, .resume_instruction,
      .vmxe_wr, .vmxe_wr_val, .vmx_enter_root, .vmx_enter_guest, .vmx_leave, .vmx_instr,
      .virt_control_structure_ptr_in, .stack_descriptor_privilege, .virtual_8086_flag, .shadow_blk_in,
      .vnmi_blk_in, .vnmi_ctl_in, .mtf_pending_in, .ept_ctl_in, .extended_table_pointer_in, .unrestricted_guest,
      .saved_virtualization_enable_bit, .saved_nmi_blk, .saved_base, .safer_mode_active, .intwin_ctl,
      .intwin_cond, .nmiwin_ctl, .nmiwin_cond, .halted, .smm_active_r, .vmxe_r,
      .vmx_root_r, .vmx_guest_r, .virt_control_structure_ptr_r, .space_locked_r, .mem_wr_r, .mem_wide_r,
      .mem_addr_r, .mem_data_r, .save_state_r, .load_std_r, .restore_state_r, .flush_vpid0_r,
      .flush_all_r, .force_fixed_r, .cpl_r, .v86_r, .shadow_blk_r, .vnmi_blk_r,
      .code_requested_privilege_r, .stack_requested_privilege_r, .shutdown_r, .smi_blocked_r,
      .nmi_blocked_r, .init_blocked_r, .address_bit20_mask_blocked_r, .gp_fault_r, .vm_exit_r, .mtf_exit_r,
      .mtf_post_r, .debug_trap_hold_r, .wake_r, .mgmt_base_address_r);

   mivs_handler_model i_mivs_handler_model (.clk_sys, .sys_rst, .fire, .keep_req, .bad_image,
      .new_base, .smm_active_r, .load_std_r, .mgmt_interrupt_req, .resume_instruction,
      .saved_virtualization_enable_bit, .saved_nmi_blk, .saved_base);

   always #2.5 clk_sys = ~clk_sys;

   // pulses only stand one cycle, so they are logged here rather than polled
   always @(posedge clk_sys) begin
      #1;
      cyc++;
      if (smm_active_r === 1'b1 && smm_q !== 1'b1) t_in = cyc;
      smm_q = smm_active_r;
      if (mem_wr_r === 1'b1 && mem_wide_r === 1'b0) begin
         n_ctl++;
         ctl_a = mem_addr_r;
         ctl_d = mem_data_r;
      end
      if (mem_wr_r === 1'b1 && mem_wide_r === 1'b1) begin
         n_wide++;
         wide_a = mem_addr_r;
         wide_d = mem_data_r;
      end
      if (flush_vpid0_r === 1'b1) t_fl = cyc;
      if (flush_all_r === 1'b1 && restore_state_r === 1'b1) n_fa++;
      if (save_state_r === 1'b1) n_sv++;
      if (force_fixed_r === 1'b1) n_ff++;
      if (gp_fault_r === 1'b1) n_gp++;
      if (vm_exit_r === 1'b1) n_vx++;
      if (mtf_exit_r === 1'b1) begin
         n_mtf++;
         wk = wake_r;
      end
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : tick

   task automatic clr;
      {n_ctl, n_wide, n_fa, n_gp, n_vx, n_mtf, n_sv, n_ff} = '0;
   endtask : clr

   task automatic go_in;
      fire <= 1'b1;
      tick(1);
      fire <= 1'b0;
      for (int i = 0; i < 20 && smm_active_r !== 1'b1; i++) tick(1);
      tick(7);
   endtask : go_in

   task automatic go_out(input int settle);
      for (int i = 0; i < 40 && smm_active_r !== 1'b0; i++) tick(1);
      tick(settle);
   endtask : go_out

   task automatic t_reset;
      chk(mgmt_base_address_r, 32'h0003_0000);
      chk({smm_active_r, vmxe_r, shutdown_r}, 3'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_root;
      vmxe_wr <= 1'b1;
      vmxe_wr_val <= 1'b1;
      tick(1);
      vmxe_wr <= 1'b0;
      vmx_enter_root <= 1'b1;
      tick(1);
      vmx_enter_root <= 1'b0;
      clr();
      go_in();
      chk(vmx_root_r, 0);
      chk(vmxe_r, 0);
      chk(space_locked_r, 1);
      chk({smi_blocked_r, init_blocked_r}, 2'h3);
      chk(ctl_a, 32'h0003_fee0);
      chk(ctl_d, 0);
      chk(n_wide, 0);
      chk(n_sv, 1);
      chk(t_fl - t_in, 4);
      vmxe_wr <= 1'b1;
      tick(1);
      vmxe_wr <= 1'b0;
      vmx_instr <= 1'b1;
      tick(1);
      vmx_instr <= 1'b0;
      tick(2);
      chk(n_gp, 2);
      chk(vmxe_r, 0);
      go_out(2);
      chk({vmxe_r, vmx_root_r, vmx_guest_r}, 3'h6);
      chk(virt_control_structure_ptr_r, virt_control_structure_ptr_in);
      chk({code_requested_privilege_r, stack_requested_privilege_r}, 4'ha);
      chk({smi_blocked_r, nmi_blocked_r, init_blocked_r}, 3'h1);
      chk(address_bit20_mask_blocked_r, 1);
      chk(n_fa, 1);
      chk(n_ff, 1);
      chk(mgmt_base_address_r, 32'h0005_0000);
      chk(space_locked_r, 0);
      $display("test root done");
   endtask : t_root

   task automatic t_guest;
      vmx_enter_guest <= 1'b1;
      tick(1);
      vmx_enter_guest <= 1'b0;
      {ept_ctl_in, vnmi_ctl_in, vnmi_blk_in, mtf_pending_in, virtual_8086_flag} <= 5'h1f;
      {intwin_ctl, intwin_cond, init_req, halted} <= 4'hf;
      shadow_blk_in <= 1'b1;
      stack_descriptor_privilege <= 2'h3;
      clr();
      go_in();
      chk(vmx_guest_r, 0);
      chk({ctl_a, ctl_d[31:0]}, {32'h0005_fee0, 32'h1});
      chk(wide_a, 32'h0005_fed8);
      chk(wide_d, extended_table_pointer_in);
      chk(t_fl - t_in, 5);
      chk({cpl_r, v86_r, vnmi_blk_r, shadow_blk_r}, 5'h1f);
      chk(n_vx, 0);
      go_out(2);
      chk({vmx_guest_r, init_blocked_r, nmi_blocked_r}, 3'h4);
      chk(n_vx, 1);
      chk({code_requested_privilege_r, stack_requested_privilege_r}, 4'ha);
      chk({mtf_post_r, debug_trap_hold_r}, 2'h3);
      chk(n_mtf, 0);
      init_req <= 1'b0;
      {intwin_ctl, mtf_pending_in} <= 2'h0;
      tick(3);
      chk(n_mtf, 1);
      chk(wk, 1);
      chk(mtf_post_r, 0);
      $display("test guest done");
   endtask : t_guest

   task automatic t_hold;
      keep_req <= 1'b1;
      {nmiwin_ctl, nmiwin_cond} <= 2'h3;
      clr();
      go_in();
      go_out(0);
      chk(n_ctl, 1);
      tick(1);
      chk(smm_active_r, 1);
      keep_req <= 1'b0;
      tick(7);
      go_out(2);
      chk(n_ctl, 2);
      chk(n_vx, 2);
      {nmiwin_ctl, nmiwin_cond} <= 2'h0;
      $display("test hold done");
   endtask : t_hold

   task automatic t_shut;
      init_req <= 1'b1;
      tick(2);
      init_req <= 1'b0;
      chk(mgmt_base_address_r, 32'h0005_0000);
      {bad_image, mtf_pending_in} <= 2'h3;
      clr();
      go_in();
      tick(30);
      chk(shutdown_r, 1);
      chk(n_fa, 0);
      chk({n_mtf[0], mtf_post_r}, 2'h0);
      sys_rst <= 1'b1;
      tick(12);
      sys_rst <= 1'b0;
      bad_image <= 1'b0;
      tick(1);
      chk({mgmt_base_address_r, shutdown_r}, {32'h0003_0000, 1'b0});
      $display("test shutdown done");
   endtask : t_shut

   // enabled but outside virtualization, safer mode on: no restore of virtualization state
   task automatic t_plain;
      vmxe_wr <= 1'b1;
      tick(1);
      vmxe_wr <= 1'b0;
      vmx_enter_root <= 1'b1;
      tick(1);
      vmx_enter_root <= 1'b0;
      vmx_leave <= 1'b1;
      tick(1);
      vmx_leave <= 1'b0;
      safer_mode_active <= 1'b1;
      clr();
      go_in();
      chk({ctl_a, ctl_d[31:0]}, {32'h0003_fee0, 32'h0});
      go_out(2);
      chk({vmxe_r, vmx_root_r, vmx_guest_r}, 3'h4);
      chk({init_blocked_r, address_bit20_mask_blocked_r}, 2'h1);
      chk(n_ff, 0);
      $display("test plain done");
   endtask : t_plain

   task automatic final_report;
      $display("checks=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report

   initial begin
      {fire, keep_req, bad_image, init_req, vmxe_wr, vmxe_wr_val, vmx_enter_root} = '0;
      {vmx_enter_guest, vmx_instr, virtual_8086_flag, vnmi_blk_in, vnmi_ctl_in} = '0;
      {mtf_pending_in, ept_ctl_in, unrestricted_guest, intwin_ctl, intwin_cond, halted} = '0;
      {shadow_blk_in, safer_mode_active, vmx_leave, nmiwin_ctl, nmiwin_cond} = '0;
      stack_descriptor_privilege = 2'h2;
      new_base = 32'h0005_0000;
      virt_control_structure_ptr_in = 64'h0000_0000_0abc_d000;
      extended_table_pointer_in = 64'h0000_1234_5678_901e;
      tick(12);
      sys_rst <= 1'b0;
      tick(1);
      t_reset();
      t_root();
      t_guest();
      t_hold();
      t_shut();
      t_plain();
      final_report();
   end
endmodule : test_mgmt_interrupt_virt_state_sequencer
